//--- sep_params.svh
// Constants for the status byte and write protection block.
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_CMD_STATUS_READ  8'h05
`define SEP_CMD_STATUS_WRITE 8'h01
`define SEP_CMD_LATCH_SET    8'h06
`define SEP_CMD_LATCH_CLEAR  8'h04
`define SEP_BIT_PIN_EN       7
`define SEP_BIT_BP_HI        3
`define SEP_BIT_BP_LO        2
`define SEP_BIT_LATCH        1
`define SEP_BIT_BUSY         0
`define SEP_BP_NONE          2'h0
`define SEP_BP_QUARTER       2'h1
`define SEP_BP_HALF          2'h2
`define SEP_QUARTER_BASE     14'h3000
`define SEP_HALF_BASE        14'h2000
`define SEP_LEN_CMD_LAST     5'h07
`define SEP_LEN_DATA_LAST    5'h0F
`define SEP_LEN_SAT          5'h11
`define SEP_RST_PIN_EN       1'b0
`define SEP_RST_BP           2'h0
`define SEP_PROG_CYCLES      1000
`endif

//--- sep_pkg.sv
// Types shared by the status byte and write protection block.
`default_nettype none
package sep_pkg;
  typedef struct packed {
    logic       pin_en;
    logic [2:0] unused;
    logic [1:0] bp;
    logic       latch;
    logic       busy;
  } sep_status_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } sep_frame_t;

  typedef enum logic [2:0] {
    SEP_IDLE      = 3'b001,
    SEP_PROG_STAT = 3'b010,
    SEP_PROG_ARR  = 3'b100
  } sep_state_t;
endpackage : sep_pkg
`default_nettype wire

//--- sep_status_protect.sv
// Status byte, write latch and write protection logic of a serial memory.
//
// Overview of operation
// - Status read returns the status byte at any time, even while busy.
// - Status layout: bit7 pin enable, bits3-2 block protect, bit1 latch, bit0 busy.
// - Busy reads one during an internal write, zero otherwise; writes ignored.
// - Latch flag mirrors the write latch; the data of a status write never changes it.
// - Latch set and clear commands always update the latch.
// - Block protect bits are kept and changed only by status write.
// - Block protect codes guard none, upper quarter, upper half or whole array.
// - Pin low with pin enable set blocks only status bit writes.
// - Latch must be set first; with latch clear all writes are rejected.
// - Latch clears when an array or status write finishes.
// - After power-up idle, latch clear, output off, until select falls.
// - Status write programming starts only on select rising after a correct length sequence.
// - Array accesses during programming are ignored; programming continues.
// - Deselect enters standby, but started programming still completes.
// - Serial output stays high impedance while deselected.
// - Pin low during a status write sequence cancels it when enabled.
// - Input sampled on rising clock edges; output changes after falling edges.
// - Commands: read 05h, write 01h, latch set 06h, latch clear 04h.
// - All serial bytes travel most significant bit first.
`include "sep_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sep_status_protect #(
  parameter int ADDR_W      = 14,
  parameter int PROG_CYCLES = `SEP_PROG_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_si,
  output logic                   spi_so,
  output logic                   spi_so_oe_n,
  input  wire logic              spi_wp_n,
  input  wire logic              arr_wr_req,
  input  wire logic [ADDR_W-1:0] arr_wr_addr,
  output logic                   arr_wr_grant,
  output logic                   arr_busy,
  output logic [7:0]             status_byte
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // Returns one when the address lies in a block guarded by the code.
  function automatic logic prot_hit(input logic [1:0] bp, input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (bp)
      `SEP_BP_NONE:    hit = 1'b0;
      `SEP_BP_QUARTER: hit = (addr[13:0] >= `SEP_QUARTER_BASE);
      `SEP_BP_HALF:    hit = (addr[13:0] >= `SEP_HALF_BASE);
      default:         hit = 1'b1;
    endcase
    return hit;
  endfunction : prot_hit

  // Returns one when the captured frame carries the given command.
  function automatic logic frame_is(input sep_pkg::sep_frame_t f, input logic [7:0] code);
    return f.valid && (f.cmd == code);
  endfunction : frame_is

  // Link side, clocked by the serial clock; shift, length and output registers clear while deselected, frame and status copies do not.
  logic                 link_rst;
  logic [2:0]           bit_pos_reg;
  logic [4:0]           len_reg;
  logic [7:0]           rx_reg;
  logic [7:0]           rx_next;
  logic [7:0]           cmd_reg;
  logic [7:0]           tx_reg;
  logic                 rd_act_reg;
  logic [7:0]           stat_s1_reg;
  logic [7:0]           stat_s2_reg;
  sep_pkg::sep_frame_t  frame_reg;
  logic                 frame_tgl_reg;
  logic                 frame_ok;

  // Clock side.
  logic [2:0]           pin_s1_reg;
  logic [2:0]           pin_s2_reg;
  logic                 cs_prev_reg;
  logic                 cs_n_s;
  logic                 wp_n_s;
  logic                 tgl_s;
  logic                 frame_start;
  logic                 frame_end;
  logic                 armed_reg;
  logic                 tgl_seen_reg;
  logic                 wp_low_seen_reg;
  logic                 new_frame;
  logic                 latch_set;
  logic                 latch_clear;
  logic                 stat_wr_try;
  logic                 stat_wr_go;
  logic                 prog_done;
  logic                 pin_en_reg;
  logic [1:0]           bp_reg;
  logic                 wel_reg;
  logic [7:0]           staged_reg;
  logic [CNT_W-1:0]     cnt_reg;
  sep_pkg::sep_state_t  state_reg;
  sep_pkg::sep_status_t stat;

  assign link_rst = spi_cs_n | sys_rst;
  assign rx_next  = {rx_reg[6:0], spi_si};

  // Shifts in command and data bits on rising edges.
  always_ff @(posedge spi_sck or posedge link_rst) begin
    if (link_rst) begin
      bit_pos_reg <= 3'h0;
      len_reg     <= 5'h00;
      rx_reg      <= 8'h00;
      cmd_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      rd_act_reg  <= 1'b0;
    end else begin
      bit_pos_reg <= bit_pos_reg + 3'h1;
      rx_reg      <= rx_next;
      if (len_reg != `SEP_LEN_SAT) begin
        len_reg <= len_reg + 5'h01;
      end
      if (len_reg == `SEP_LEN_CMD_LAST) begin
        cmd_reg <= rx_next;
      end
      if (bit_pos_reg == 3'h7) begin
        tx_reg <= stat_s2_reg;
        if (len_reg == `SEP_LEN_CMD_LAST && rx_next == `SEP_CMD_STATUS_READ) begin
          rd_act_reg <= 1'b1;
        end
      end
    end
  end

  // Drives the serial output after falling edges, first bit the top one.
  always_ff @(negedge spi_sck or posedge link_rst) begin
    if (link_rst) begin
      spi_so      <= 1'b0;
      spi_so_oe_n <= 1'b1;
    end else begin
      spi_so      <= tx_reg[~bit_pos_reg];
      spi_so_oe_n <= ~rd_act_reg;
    end
  end

  // Marks a frame whose length exactly fits a latch or status write command.
  always_comb begin
    frame_ok = 1'b0;
    if (len_reg == `SEP_LEN_CMD_LAST) begin
      frame_ok = (rx_next == `SEP_CMD_LATCH_SET) || (rx_next == `SEP_CMD_LATCH_CLEAR);
    end else if (len_reg == `SEP_LEN_DATA_LAST) begin
      frame_ok = (cmd_reg == `SEP_CMD_STATUS_WRITE);
    end
  end

  // Holds the frame result for the clock side; any extra bit spoils it.
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      frame_reg     <= '0;
      frame_tgl_reg <= 1'b0;
    end else begin
      frame_reg.valid <= frame_ok;
      frame_reg.cmd   <= (len_reg == `SEP_LEN_CMD_LAST) ? rx_next : cmd_reg;
      frame_reg.data  <= rx_next;
      if (frame_ok) begin
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  // Brings the whole status byte into the serial clock domain through two register stages.
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      stat_s1_reg <= 8'h00;
      stat_s2_reg <= 8'h00;
    end else begin
      stat_s1_reg <= status_byte;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // Synchronises select, protect pin and frame toggle into the clock domain.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_reg  <= 3'b110;
      pin_s2_reg  <= 3'b110;
      cs_prev_reg <= 1'b1;
    end else begin
      pin_s1_reg  <= {spi_cs_n, spi_wp_n, frame_tgl_reg};
      pin_s2_reg  <= pin_s1_reg;
      cs_prev_reg <= pin_s2_reg[2];
    end
  end

  assign cs_n_s      = pin_s2_reg[2];
  assign wp_n_s      = pin_s2_reg[1];
  assign tgl_s       = pin_s2_reg[0];
  assign frame_start = ~cs_n_s & cs_prev_reg;
  assign frame_end   = cs_n_s & ~cs_prev_reg;

  // Tracks the first select fall after power-up and the protect pin per frame.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed_reg       <= 1'b0;
      tgl_seen_reg    <= 1'b0;
      wp_low_seen_reg <= 1'b0;
    end else begin
      if (frame_start) begin
        armed_reg <= 1'b1;
      end
      if (frame_end) begin
        tgl_seen_reg <= tgl_s;
      end
      if (frame_start) begin
        wp_low_seen_reg <= ~wp_n_s;
      end else if (~cs_n_s && ~wp_n_s) begin
        wp_low_seen_reg <= 1'b1;
      end
    end
  end

  assign new_frame   = frame_end && armed_reg && (tgl_s != tgl_seen_reg);
  assign latch_set   = new_frame && frame_is(frame_reg, `SEP_CMD_LATCH_SET);
  assign latch_clear = new_frame && frame_is(frame_reg, `SEP_CMD_LATCH_CLEAR);
  assign stat_wr_try = new_frame && frame_is(frame_reg, `SEP_CMD_STATUS_WRITE);
  assign stat_wr_go  = stat_wr_try && wel_reg && (state_reg == sep_pkg::SEP_IDLE)
                       && !(pin_en_reg && (wp_low_seen_reg || ~wp_n_s));
  assign prog_done   = (state_reg != sep_pkg::SEP_IDLE) && (cnt_reg == '0);

  // Grants an array write only when latched, idle and outside guarded blocks.
  assign arr_wr_grant = arr_wr_req && wel_reg && (state_reg == sep_pkg::SEP_IDLE)
                        && !prot_hit(bp_reg, arr_wr_addr);
  assign arr_busy     = (state_reg != sep_pkg::SEP_IDLE);

  // Runs the internal programming cycle independently of the select pin.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg  <= sep_pkg::SEP_IDLE;
      cnt_reg    <= '0;
      staged_reg <= 8'h00;
    end else begin
      case (state_reg)
        sep_pkg::SEP_IDLE: begin
          if (stat_wr_go) begin
            state_reg  <= sep_pkg::SEP_PROG_STAT;
            staged_reg <= frame_reg.data;
            cnt_reg    <= CNT_W'(PROG_CYCLES - 1);
          end else if (arr_wr_grant) begin
            state_reg <= sep_pkg::SEP_PROG_ARR;
            cnt_reg   <= CNT_W'(PROG_CYCLES - 1);
          end
        end
        sep_pkg::SEP_PROG_STAT, sep_pkg::SEP_PROG_ARR: begin
          if (cnt_reg == '0) begin
            state_reg <= sep_pkg::SEP_IDLE;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        default: begin
          state_reg <= sep_pkg::SEP_IDLE;
        end
      endcase
    end
  end

  // Keeps the protection bits; only a finished status write changes them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_en_reg <= `SEP_RST_PIN_EN;
      bp_reg     <= `SEP_RST_BP;
    end else if (prog_done && state_reg == sep_pkg::SEP_PROG_STAT) begin
      pin_en_reg <= staged_reg[`SEP_BIT_PIN_EN];
      bp_reg     <= staged_reg[`SEP_BIT_BP_HI:`SEP_BIT_BP_LO];
    end
  end

  // Write latch: the set command wins over a finishing write in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wel_reg <= 1'b0;
    end else if (latch_set) begin
      wel_reg <= 1'b1;
    end else if (latch_clear || prog_done) begin
      wel_reg <= 1'b0;
    end
  end

  // Builds the status byte from the latch, busy and protection state.
  always_comb begin
    stat        = '0;
    stat.pin_en = pin_en_reg;
    stat.unused = 3'h0;
    stat.bp     = bp_reg;
    stat.latch  = wel_reg;
    stat.busy   = (state_reg != sep_pkg::SEP_IDLE);
  end
  assign status_byte = stat;

  AST_BUSY_ON_WRITE : assert property (@(posedge clk) disable iff (sys_rst)
    stat_wr_go |=> status_byte[`SEP_BIT_BUSY] ##1 status_byte[`SEP_BIT_BUSY])
    else $error("busy flag not raised by status write");
  AST_LATCH_SET : assert property (@(posedge clk) disable iff (sys_rst)
    latch_set |=> status_byte[`SEP_BIT_LATCH])
    else $error("latch set command ignored");
  AST_LATCH_CLEAR : assert property (@(posedge clk) disable iff (sys_rst)
    (latch_clear && !latch_set) |=> !status_byte[`SEP_BIT_LATCH])
    else $error("latch clear command ignored");
  AST_LATCH_NEEDS_CMD : assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wel_reg) |-> $past(latch_set))
    else $error("latch set without a latch set command");
  AST_BP_STABLE : assert property (@(posedge clk) disable iff (sys_rst)
    !(prog_done && state_reg == sep_pkg::SEP_PROG_STAT) |=> $stable(bp_reg))
    else $error("block protect changed outside status write");
  AST_GRANT_UNGUARDED : assert property (@(posedge clk) disable iff (sys_rst)
    arr_wr_grant |-> (bp_reg == 2'h0) || (bp_reg == 2'h1 && arr_wr_addr[13:12] != 2'h3)
                     || (bp_reg == 2'h2 && arr_wr_addr[13] == 1'b0))
    else $error("write granted into a guarded block");
  AST_STAT_NEEDS_LATCH : assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == sep_pkg::SEP_IDLE ##1 state_reg == sep_pkg::SEP_PROG_STAT) |-> $past(wel_reg))
    else $error("status write started with latch clear");
  AST_LATCH_CLR_DONE : assert property (@(posedge clk) disable iff (sys_rst)
    (prog_done && !latch_set) |=> !status_byte[`SEP_BIT_LATCH])
    else $error("latch not cleared after write");
  AST_NO_GRANT_BUSY : assert property (@(posedge clk) disable iff (sys_rst)
    arr_busy |-> !arr_wr_grant)
    else $error("array write granted while programming");
  AST_PROG_HOLDS : assert property (@(posedge clk) disable iff (sys_rst)
    $rose(arr_busy) |-> arr_busy[*8])
    else $error("programming cycle cut short");
  AST_SO_OFF : assert property (@(posedge clk) disable iff (sys_rst)
    (cs_n_s && spi_cs_n) |-> spi_so_oe_n)
    else $error("serial output driven while deselected");
  AST_PIN_CANCEL : assert property (@(posedge clk) disable iff (sys_rst)
    (stat_wr_try && pin_en_reg && wp_low_seen_reg && state_reg == sep_pkg::SEP_IDLE)
    |=> state_reg == sep_pkg::SEP_IDLE)
    else $error("status write not cancelled by protect pin");
  AST_UNUSED_ZERO : assert property (@(posedge clk) disable iff (sys_rst)
    status_byte[6:4] == 3'h0)
    else $error("unused status bits not zero");
endmodule : sep_status_protect
`default_nettype wire

//--- sep_host_model.sv
// Serial host model that frames commands on the link of the status block.
`include "sep_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sep_host_model (
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_si,
  input  wire logic spi_so,
  input  wire logic spi_so_oe_n
);
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_si   = 1'b0;
  end

  // Sends the low nbits of tx and gathers the bits seen on rising edges.
  task automatic xfer(input int nbits, input logic [15:0] tx, output logic [7:0] rx, output logic drv);
    rx = 8'h00;
    drv = 1'b1;
    spi_cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_si = tx[i];
      #3 spi_sck = 1'b1;
      rx = {rx[6:0], spi_so};
      if (i < 8) begin
        drv = drv & ~spi_so_oe_n;
      end
      #3 spi_sck = 1'b0;
    end
    #3 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #40;
  endtask : xfer
endmodule : sep_host_model
`default_nettype wire

//--- sep_status_protect_tb.sv
// Self-checking bench for the status byte and write protection block.
`include "sep_params.svh"
`timescale 1ns/10ps
`default_nettype none
module sep_status_protect_tb;
  localparam int PROG = 64;
  logic        clk, sys_rst, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n, spi_wp_n;
  logic        arr_wr_req, arr_wr_grant, arr_busy, drv;
  logic [13:0] arr_wr_addr, a;
  logic [7:0]  status_byte, rx, d;
  logic [13:0] corner [6] = '{14'h0000, 14'h1FFF, 14'h2000, 14'h2FFF, 14'h3000, 14'h3FFF};
  int          err_count, comparisons;

  sep_status_protect #(.ADDR_W(14), .PROG_CYCLES(PROG)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n), .spi_wp_n(spi_wp_n), .arr_wr_req(arr_wr_req),
    .arr_wr_addr(arr_wr_addr), .arr_wr_grant(arr_wr_grant), .arr_busy(arr_busy), .status_byte(status_byte));
  sep_host_model host_u (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe_n(spi_so_oe_n));

  always #2.5 clk = ~clk;

  task automatic final_report;
    $display("Counts: %0d mismatches in %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  function automatic logic exp_grant(input logic [1:0] bp, input logic [13:0] ad);
    case (bp)
      2'h0: return 1'b1;
      2'h1: return ad < 14'h3000;
      2'h2: return ad < 14'h2000;
      default: return 1'b0;
    endcase
  endfunction : exp_grant

  task automatic wait_idle;
    int n = 0;
    while (arr_busy !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        err_count++;
        $display("wrong value at %0t: busy never cleared", $time);
        final_report();
      end
    end
  endtask : wait_idle

  task automatic cmd(input logic [7:0] c);
    host_u.xfer(8, {8'h00, c}, rx, drv);
  endtask : cmd

  task automatic status_write_cmd(input logic [7:0] v, input logic busy_exp);
    host_u.xfer(16, {`SEP_CMD_STATUS_WRITE, v}, rx, drv);
    @(negedge clk);
    chk_bit(arr_busy, busy_exp);
  endtask : status_write_cmd

  task automatic status_read_cmd(input logic [7:0] exp);
    host_u.xfer(16, {`SEP_CMD_STATUS_READ, 8'h00}, rx, drv);
    chk_byte(rx, exp);
    chk_bit(drv, 1'b1);
    chk_bit(spi_so_oe_n, 1'b1);
  endtask : status_read_cmd

  task automatic arr_try(input logic [13:0] ad, input logic exp);
    @(negedge clk);
    arr_wr_req = 1'b1;
    arr_wr_addr = ad;
    #1 chk_bit(arr_wr_grant, exp);
    @(negedge clk);
    arr_wr_req = 1'b0;
    if (exp) begin
      @(negedge clk);
      chk_bit(arr_busy, 1'b1);
      wait_idle();
      chk_bit(status_byte[`SEP_BIT_LATCH], 1'b0);
    end
  endtask : arr_try

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    spi_wp_n = 1'b1;
    arr_wr_req = 1'b0;
    arr_wr_addr = 14'h0000;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h7D6C));
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_byte(status_byte, 8'h00);
    chk_bit(spi_so_oe_n, 1'b1);
    arr_try(14'h0000, 1'b0);
    cmd(`SEP_CMD_LATCH_SET);
    chk_bit(status_byte[`SEP_BIT_LATCH], 1'b1);
    host_u.xfer(9, 16'h0008, rx, drv);
    chk_bit(status_byte[`SEP_BIT_LATCH], 1'b1);
    cmd(`SEP_CMD_LATCH_CLEAR);
    chk_bit(status_byte[`SEP_BIT_LATCH], 1'b0);
    status_write_cmd(8'hFF, 1'b0);
    chk_byte(status_byte, 8'h00);
    d = 8'($urandom) & 8'h7F;
    cmd(`SEP_CMD_LATCH_SET);
    status_write_cmd(d, 1'b1);
    status_read_cmd(8'h03);
    arr_try(14'h0000, 1'b0);
    wait_idle();
    chk_byte(status_byte, {4'h0, d[3:2], 2'h0});
    for (int b = 0; b < 4; b++) begin
      d = 8'($urandom) & 8'h73;
      cmd(`SEP_CMD_LATCH_SET);
      status_write_cmd(d | {4'h0, 2'(b), 2'h0}, 1'b1);
      wait_idle();
      status_read_cmd({4'h0, 2'(b), 2'h0});
      for (int k = 0; k < 8; k++) begin
        a = (k < 6) ? corner[k] : 14'($urandom);
        cmd(`SEP_CMD_LATCH_SET);
        arr_try(a, exp_grant(2'(b), a));
      end
    end
    cmd(`SEP_CMD_LATCH_SET);
    status_write_cmd(8'h80, 1'b1);
    wait_idle();
    spi_wp_n = 1'b0;
    cmd(`SEP_CMD_LATCH_SET);
    status_write_cmd(8'h8C, 1'b0);
    chk_byte(status_byte, 8'h82);
    arr_try(14'h3FFF, 1'b1);
    chk_byte(status_byte, 8'h80);
    spi_wp_n = 1'b1;
    cmd(`SEP_CMD_LATCH_SET);
    status_write_cmd(8'h04, 1'b1);
    spi_wp_n = 1'b0;
    wait_idle();
    chk_byte(status_byte, 8'h04);
    cmd(`SEP_CMD_LATCH_SET);
    status_write_cmd(8'h08, 1'b1);
    wait_idle();
    chk_byte(status_byte, 8'h08);
    final_report();
  end
endmodule : sep_status_protect_tb
`default_nettype wire
